// ===== rtl/gpp_pkg.sv
// Constants shared by the general-purpose I/O port and its pin cells.
// Assumes a 16-bit peripheral bus with word addresses and a 100 MHz clock.
`default_nettype none
package gpp_pkg;
  // Peripheral bus geometry.
  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 16;
  // Dedicated port.
  localparam int          PORT_W         = 8;
  localparam logic [15:0] PORT_DIR_ADDR  = 16'h3400;
  localparam logic [15:0] PORT_LVL_ADDR  = 16'h3401;
  localparam logic [7:0]  PORT_DIR_RST   = 8'h00;
  localparam int          STRAP_BIT      = 7;
  localparam int          SHARED_A_BIT   = 3;
  localparam int          SHARED_B_BIT   = 5;
  // Extended I/O: three register sets of enable, direction and level.
  localparam int          EXT_W          = 46;
  localparam int          EXT_SETS       = 3;
  localparam int          EXT_PAD_W      = EXT_SETS * DATA_W;
  localparam logic [15:0] EXT_BASE_ADDR  = 16'h4400;
  localparam logic [15:0] EXT_LAST_ADDR  = 16'h4408;
  localparam logic [1:0]  EXT_KIND_EN    = 2'h0;
  localparam logic [1:0]  EXT_KIND_DIR   = 2'h1;
  localparam logic [1:0]  EXT_KIND_LVL   = 2'h2;
  localparam logic [1:0]  EXT_KIND_CNT   = 2'h3;
  localparam logic [45:0] EXT_EN_RST     = 46'h0000_0000_0000;
  localparam logic [45:0] EXT_DIR_RST    = 46'h0000_0000_0000;
  // Bus mux field value that hands the pins to the memory and host interfaces.
  localparam logic        MUX_FULL_MEM   = 1'b1;
  // Answer to reads of reserved bits and unmapped addresses.
  localparam logic [15:0] READ_ZERO      = 16'h0000;
endpackage : gpp_pkg
`default_nettype wire

// ===== rtl/gpp_io_cell.sv
// Registered pin cell: drives, releases or hands over a group of pins.
// Assumes pin inputs are synchronous to clk; output enables are active low.
`default_nettype none
module gpp_io_cell
  import gpp_pkg::*;
#(
  parameter int WIDTH = PORT_W
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Control from the register file.
  input  wire logic [WIDTH-1:0] enable,
  input  wire logic [WIDTH-1:0] dir,
  input  wire logic [WIDTH-1:0] latch,
  // Alternate function that may take a pin over.
  input  wire logic [WIDTH-1:0] altSel,
  input  wire logic [WIDTH-1:0] altOut,
  input  wire logic [WIDTH-1:0] altOeN,
  // Pin side.
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut,
  output logic      [WIDTH-1:0] pinOeN,
  output logic      [WIDTH-1:0] pinSample
);
  logic [WIDTH-1:0] next_pinOut;
  logic [WIDTH-1:0] next_pinOeN;

  ////////////////////////////////////////////////////////////////////////////
  // Each pin is driven by its latch only when enabled and set as an output.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (altSel[i]) begin
        next_pinOut[i] = altOut[i];
        next_pinOeN[i] = altOeN[i];
      end else begin
        next_pinOut[i] = latch[i];
        next_pinOeN[i] = ~(enable[i] & dir[i]);
      end
    end
  end

  // Outputs and the input sample are all plain flops, so reads see one cycle of latency.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut    <= '0;
      pinOeN    <= '1;
      pinSample <= '0;
    end else begin
      pinOut    <= next_pinOut;
      pinOeN    <= next_pinOeN;
      pinSample <= pinIn;
    end
  end
endmodule : gpp_io_cell
`default_nettype wire

// ===== rtl/gpp_port.sv
// General-purpose I/O port: eight dedicated pins, two shared serial pins and
// 46 extended pins lent by the memory and host interfaces.
// Assumes a simple word-addressed peripheral bus with a select strobe and a
// write flag, and that the bus mux field comes from the bus select register.
//
// Function
// - Eight bit-selectable pins, bit 0 least significant.
// - Direction at 0x3400, level at 0x3401.
// - Direction 1 output, 0 input; resets zero.
// - Port register bits 15:8 read zero.
// - Input pin level bit reads sampled pin.
// - Output pin driven by written level bit.
// - Level reads follow pins after reset.
// - Strap pin low selects port bits three, five.
// - Strap pin high selects serial clock, sync.
// - Shared pin choice latched at reset release.
// - Extended I/O only in non-multiplexed mode.
// - Extended numbering: address, data, control, host.
// - Mux field one gives pins to interfaces.
// - Extended enable bit: general I/O or released.
// - Extended direction bit selects input or output.
// - Extended level bit holds read/written value.
// - Enable bits never override the mux field.
// - Extended sets from 0x4400; enable, direction reset zero.
// - Extended level reads pin or drives pin.
`default_nettype none
module gpp_port
  import gpp_pkg::*;
#(
  parameter int PORT_WIDTH = PORT_W,
  parameter int EXT_WIDTH  = EXT_W
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // Peripheral bus slave.
  input  wire logic                  regSel,
  input  wire logic                  regWrite,
  input  wire logic [ADDR_W-1:0]     regAddr,
  input  wire logic [DATA_W-1:0]     regWdata,
  output logic      [DATA_W-1:0]     regRdata,
  output logic                       regAck,
  // Bus mux field of the bus select register.
  input  wire logic                  busMuxMode,
  // Second serial port transmit signals for the shared pins.
  input  wire logic                  serial2TxClock,
  input  wire logic                  serial2TxClockOeN,
  input  wire logic                  serial2TxFrameSync,
  input  wire logic                  serial2TxFrameSyncOeN,
  // Dedicated port pins; bits 3 and 5 are the shared pins.
  input  wire logic [PORT_WIDTH-1:0] portPinIn,
  output logic      [PORT_WIDTH-1:0] portPinOut,
  output logic      [PORT_WIDTH-1:0] portPinOeN,
  // Extended I/O pins.
  input  wire logic [EXT_WIDTH-1:0]  extPinIn,
  output logic      [EXT_WIDTH-1:0]  extPinOut,
  output logic      [EXT_WIDTH-1:0]  extPinOeN,
  // Shared pin function: 1 while the shared pins serve the serial port.
  output logic                       sharedSerialMode,
  // 1 while the extended pins are lent to this block.
  output logic                       extIoActive
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding for the extended register sets.

  // Returns {hit, set, kind} for an address in the extended register range.
  function automatic logic [4:0] decodeExt(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] off;
    off = addr - EXT_BASE_ADDR;
    if (addr >= EXT_BASE_ADDR && addr <= EXT_LAST_ADDR) begin
      decodeExt = {1'b1, off[1:0] / 2'(1) == 2'h0 ? 2'(off / ADDR_W'(EXT_KIND_CNT)) :
                   2'(off / ADDR_W'(EXT_KIND_CNT)), 2'(off % ADDR_W'(EXT_KIND_CNT))};
    end else begin
      decodeExt = {1'b0, 2'h0, 2'h0};
    end
  endfunction : decodeExt

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [PORT_WIDTH-1:0] portDir;
  logic [PORT_WIDTH-1:0] portLatch;
  logic [EXT_WIDTH-1:0]  extEn;
  logic [EXT_WIDTH-1:0]  extDir;
  logic [EXT_WIDTH-1:0]  extLatch;
  logic                  strapTaken;
  logic                  strapSerial;
  logic                  sampleValid;
  logic                  next_sampleValid;

  logic [PORT_WIDTH-1:0] next_portDir;
  logic [PORT_WIDTH-1:0] next_portLatch;
  logic [EXT_WIDTH-1:0]  next_extEn;
  logic [EXT_WIDTH-1:0]  next_extDir;
  logic [EXT_WIDTH-1:0]  next_extLatch;
  logic                  next_strapTaken;
  logic                  next_strapSerial;
  logic [DATA_W-1:0]     next_regRdata;
  logic                  next_regAck;
  logic                  next_extIoActive;

  logic [PORT_WIDTH-1:0] portSample;
  logic [EXT_WIDTH-1:0]  extSample;
  logic [4:0]            extDec;
  logic                  extHit;
  logic [1:0]            extSet;
  logic [1:0]            extKind;
  logic [EXT_PAD_W-1:0]  extEnPad;
  logic [EXT_PAD_W-1:0]  extDirPad;
  logic [EXT_PAD_W-1:0]  extLvlPad;
  logic [PORT_WIDTH-1:0] portLvlView;

  assign extDec  = decodeExt(regAddr);
  assign extHit  = extDec[4];
  assign extSet  = extDec[3:2];
  assign extKind = extDec[1:0];

  // Read views: output pins show their latch, input pins their sample.
  assign portLvlView = (portDir & portLatch) | (~portDir & portSample);
  assign extEnPad    = {(EXT_PAD_W - EXT_WIDTH)'(0), extEn};
  assign extDirPad   = {(EXT_PAD_W - EXT_WIDTH)'(0), extDir};
  assign extLvlPad   = {(EXT_PAD_W - EXT_WIDTH)'(0),
                        (extDir & extLatch) | (~extDir & extSample)};

  ////////////////////////////////////////////////////////////////////////////
  // Next values of all registers and of the bus answer.
  always_comb begin
    next_portDir     = portDir;
    next_portLatch   = portLatch;
    next_extEn       = extEn;
    next_extDir      = extDir;
    next_extLatch    = extLatch;
    next_sampleValid = 1'b1;
    next_strapTaken  = sampleValid;
    next_strapSerial = strapSerial;
    next_regAck      = regSel;
    next_regRdata    = READ_ZERO;
    next_extIoActive = (busMuxMode != MUX_FULL_MEM);

    // The strap is caught on the second edge after reset release: the sample
    // flop still holds its reset value at the first edge, so capturing then
    // would always pick the port function. It then stays fixed until reset.
    if (sampleValid && !strapTaken) begin
      next_strapSerial = portSample[STRAP_BIT];
    end

    if (regSel && regWrite) begin
      // Only the low bits exist; writes to bits above are dropped.
      if (regAddr == PORT_DIR_ADDR) begin
        next_portDir = regWdata[PORT_WIDTH-1:0];
      end
      // Writes land in the latch whatever the direction, ready for later.
      if (regAddr == PORT_LVL_ADDR) begin
        next_portLatch = regWdata[PORT_WIDTH-1:0];
      end
      if (extHit) begin
        for (int i = 0; i < EXT_WIDTH; i++) begin
          if (int'(extSet) == i / DATA_W) begin
            unique case (extKind)
              EXT_KIND_EN:  next_extEn[i]    = regWdata[i % DATA_W];
              EXT_KIND_DIR: next_extDir[i]   = regWdata[i % DATA_W];
              EXT_KIND_LVL: next_extLatch[i] = regWdata[i % DATA_W];
              default:      next_extLatch[i] = extLatch[i];
            endcase
          end
        end
      end
    end

    if (regSel && !regWrite) begin
      if (regAddr == PORT_DIR_ADDR) begin
        next_regRdata = {(DATA_W - PORT_WIDTH)'(0), portDir};
      end else if (regAddr == PORT_LVL_ADDR) begin
        next_regRdata = {(DATA_W - PORT_WIDTH)'(0), portLvlView};
      end else if (extHit) begin
        unique case (extKind)
          EXT_KIND_EN:  next_regRdata = extEnPad[extSet * DATA_W +: DATA_W];
          EXT_KIND_DIR: next_regRdata = extDirPad[extSet * DATA_W +: DATA_W];
          EXT_KIND_LVL: next_regRdata = extLvlPad[extSet * DATA_W +: DATA_W];
          default:      next_regRdata = READ_ZERO;
        endcase
      end
    end
  end

  // Register file and bus answer; the level latches reset to zero, even
  // though reads of input pins return the pin, not the latch.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      portDir          <= PORT_DIR_RST;
      portLatch        <= '0;
      extEn            <= EXT_EN_RST[EXT_WIDTH-1:0];
      extDir           <= EXT_DIR_RST[EXT_WIDTH-1:0];
      extLatch         <= '0;
      strapTaken       <= 1'b0;
      strapSerial      <= 1'b0;
      sampleValid      <= 1'b0;
      regRdata         <= READ_ZERO;
      regAck           <= 1'b0;
      sharedSerialMode <= 1'b0;
      extIoActive      <= 1'b0;
    end else begin
      portDir          <= next_portDir;
      portLatch        <= next_portLatch;
      extEn            <= next_extEn;
      extDir           <= next_extDir;
      extLatch         <= next_extLatch;
      strapTaken       <= next_strapTaken;
      strapSerial      <= next_strapSerial;
      sampleValid      <= next_sampleValid;
      regRdata         <= next_regRdata;
      regAck           <= next_regAck;
      sharedSerialMode <= next_strapSerial;
      extIoActive      <= next_extIoActive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dedicated port pins. Bits 3 and 5 are handed to the serial port when
  // the strap picked that function; until the strap is caught they stay
  // ports, which is harmless because every port pin is an input then.

  logic [PORT_WIDTH-1:0] portAltSel;
  logic [PORT_WIDTH-1:0] portAltOut;
  logic [PORT_WIDTH-1:0] portAltOeN;

  always_comb begin
    portAltSel = '0;
    portAltOut = '0;
    portAltOeN = '1;
    portAltSel[SHARED_A_BIT] = next_strapSerial;
    portAltSel[SHARED_B_BIT] = next_strapSerial;
    portAltOut[SHARED_A_BIT] = serial2TxClock;
    portAltOeN[SHARED_A_BIT] = serial2TxClockOeN;
    portAltOut[SHARED_B_BIT] = serial2TxFrameSync;
    portAltOeN[SHARED_B_BIT] = serial2TxFrameSyncOeN;
  end

  gpp_io_cell #(
    .WIDTH     (PORT_WIDTH)
  ) u_port_cell (
    .clk       (clk),
    .arst_n    (arst_n),
    .enable    ({PORT_WIDTH{1'b1}}),
    .dir       (next_portDir),
    .latch     (next_portLatch),
    .altSel    (portAltSel),
    .altOut    (portAltOut),
    .altOeN    (portAltOeN),
    .pinIn     (portPinIn),
    .pinOut    (portPinOut),
    .pinOeN    (portPinOeN),
    .pinSample (portSample)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Extended pins, numbered address 3:0, data 19:4, control 35:20, host
  // data 43:36 and host controls 44 and 45. When the mux field gives the
  // pins to the memory and host interfaces this block releases them all,
  // whatever the enable bits say.

  logic [EXT_WIDTH-1:0] extGate;

  assign extGate = next_extEn & {EXT_WIDTH{next_extIoActive}};

  gpp_io_cell #(
    .WIDTH     (EXT_WIDTH)
  ) u_ext_cell (
    .clk       (clk),
    .arst_n    (arst_n),
    .enable    (extGate),
    .dir       (next_extDir),
    .latch     (next_extLatch),
    .altSel    ({EXT_WIDTH{1'b0}}),
    .altOut    ({EXT_WIDTH{1'b0}}),
    .altOeN    ({EXT_WIDTH{1'b1}}),
    .pinIn     (extPinIn),
    .pinOut    (extPinOut),
    .pinOeN    (extPinOeN),
    .pinSample (extSample)
  );

endmodule : gpp_port
`default_nettype wire

// ===== bench/gpp_pin_model.sv
// Board model for the port pins: a released pin shows the board level.
// Assumes active-low output enables from the port.
`default_nettype none
module gpp_pin_model
  import gpp_pkg::*;
(
  // Port drive.
  input  wire logic [PORT_W-1:0] portPinOut,
  input  wire logic [PORT_W-1:0] portPinOeN,
  input  wire logic [EXT_W-1:0]  extPinOut,
  input  wire logic [EXT_W-1:0]  extPinOeN,
  // Board levels and resolved pins.
  input  wire logic [PORT_W-1:0] portBoard,
  input  wire logic [EXT_W-1:0]  extBoard,
  output logic      [PORT_W-1:0] portPinIn,
  output logic      [EXT_W-1:0]  extPinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins fall back to the board so a stale drive never reads back.
  assign portPinIn = (portPinOeN & portBoard) | (~portPinOeN & portPinOut);
  assign extPinIn  = (extPinOeN & extBoard) | (~extPinOeN & extPinOut);
endmodule : gpp_pin_model
`default_nettype wire

// ===== bench/gpp_port_asserts.sv
// Checker for the port's bus, pin and strap behaviour.
// Assumes it is bound to the port and sees only its ports.
`default_nettype none
module gpp_port_asserts
  import gpp_pkg::*;
(
  // Clock and reset.
  input wire logic              clk,
  input wire logic              arst_n,
  // Register bus.
  input wire logic              regSel,
  input wire logic              regWrite,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic [DATA_W-1:0] regRdata,
  input wire logic              regAck,
  // Pins and modes.
  input wire logic              busMuxMode,
  input wire logic              serial2TxClockOeN,
  input wire logic [PORT_W-1:0] portPinOeN,
  input wire logic [EXT_W-1:0]  extPinOeN,
  input wire logic              sharedSerialMode,
  input wire logic              extIoActive
);
  logic [1:0] relCnt;
  logic [1:0] next_relCnt;
  // Edges since release; it saturates so the strap check never rearms.
  always_comb begin
    next_relCnt = (relCnt == 2'h3) ? relCnt : relCnt + 2'h1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      relCnt <= 2'h0;
    end else begin
      relCnt <= next_relCnt;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_ack_follows: assert property (
    regSel |=> regAck) else $error("access not acknowledged");
  a_ack_cause: assert property (
    regAck |-> $past(regSel)) else $error("acknowledge without access");
  a_port_high_zero: assert property (
    regAck && $past(regSel && regAddr[15:1] == PORT_DIR_ADDR[15:1]) |-> regRdata[15:8] == 8'h00)
    else $error("reserved port bits not zero");
  a_ext_mux_off: assert property (
    busMuxMode |=> &extPinOeN) else $error("extended pin driven in memory mode");
  a_ext_active: assert property (
    1'b1 |=> extIoActive == !$past(busMuxMode)) else $error("extended mode flag wrong");
  a_strap_fixed: assert property (
    relCnt == 2'h3 |-> $stable(sharedSerialMode)) else $error("shared pin function changed");
  a_serial_pin: assert property (
    sharedSerialMode |=> portPinOeN[SHARED_A_BIT] == $past(serial2TxClockOeN))
    else $error("shared pin not given to serial clock");
  a_dir_drive: assert property (
    regSel && regWrite && regAddr == PORT_DIR_ADDR && !sharedSerialMode
    |=> portPinOeN == ~$past(regWdata[7:0])) else $error("direction write not on pins");
endmodule : gpp_port_asserts
bind gpp_port gpp_port_asserts i_gpp_port_asserts (
  .clk(clk), .arst_n(arst_n), .regSel(regSel), .regWrite(regWrite), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck), .busMuxMode(busMuxMode),
  .serial2TxClockOeN(serial2TxClockOeN), .portPinOeN(portPinOeN), .extPinOeN(extPinOeN),
  .sharedSerialMode(sharedSerialMode), .extIoActive(extIoActive));
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the port with a board model on its pins.
// Assumes the checker is bound in and the clock runs at 100 MHz.
`default_nettype none
module tb_top
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, regSel, regWrite, regAck, busMuxMode, sharedSerialMode, extIoActive;
  logic s2Clk, s2ClkOeN, s2Fs, s2FsOeN;
  logic [15:0] regAddr, regWdata, regRdata;
  logic [7:0] portPinIn, portPinOut, portPinOeN, portBoard;
  logic [45:0] extPinIn, extPinOut, extPinOeN, extBoard;
  int badCount = 0;
  int samplesChecked = 0;
  gpp_port i_gpp_port (.clk(clk), .arst_n(arst_n), .regSel(regSel), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
    .busMuxMode(busMuxMode), .serial2TxClock(s2Clk), .serial2TxClockOeN(s2ClkOeN),
    .serial2TxFrameSync(s2Fs), .serial2TxFrameSyncOeN(s2FsOeN), .portPinIn(portPinIn),
    .portPinOut(portPinOut), .portPinOeN(portPinOeN), .extPinIn(extPinIn), .extPinOut(extPinOut),
    .extPinOeN(extPinOeN), .sharedSerialMode(sharedSerialMode), .extIoActive(extIoActive));
  gpp_pin_model i_gpp_pin_model (.portPinOut(portPinOut), .portPinOeN(portPinOeN),
    .extPinOut(extPinOut), .extPinOeN(extPinOeN), .portBoard(portBoard), .extBoard(extBoard),
    .portPinIn(portPinIn), .extPinIn(extPinIn));
  ////////////////////////////////////////
  // Verdict and run end, shared by the main sequence and a hung bus.
  task automatic testDone();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : testDone
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One access: a single-cycle strobe, then a bounded wait for the acknowledge.
  task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic [15:0] r);
    int n;
    n = 0;
    @(posedge clk);
    regSel <= 1'b1;
    regWrite <= wr;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regSel <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (regAck !== 1'b1 && n < 4);
    chk("ack", 16'h0001, {15'h0000, regAck});
    if (regAck !== 1'b1) begin
      testDone();
    end
    r = regRdata;
  endtask : bus
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input string what, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] r;
    bus(1'b0, a, 16'h0000, r);
    chk(what, exp, r);
  endtask : rd
  ////////////////////////////////////////
  task automatic testReset();
    rd("port dir", PORT_DIR_ADDR, 16'h0000);
    rd("port level", PORT_LVL_ADDR, 16'h005A);
    rd("ext enable", EXT_BASE_ADDR, 16'h0000);
    chk("port oe", 16'h00FF, {8'h00, portPinOeN});
    chk("serial mode", 16'h0000, {15'h0000, sharedSerialMode});
    chk("ext active", 16'h0001, {15'h0000, extIoActive});
    $display("test reset done");
  endtask : testReset
  // Latch written while inputs, then half the pins turned to outputs.
  task automatic testPort();
    wr(PORT_LVL_ADDR, 16'hFFC3);
    wr(PORT_DIR_ADDR, 16'hFF0F);
    rd("port dir", PORT_DIR_ADDR, 16'h000F);
    chk("port oe", 16'h00F0, {8'h00, portPinOeN});
    chk("port out", 16'h0003, {12'h000, portPinOut[3:0]});
    rd("port level", PORT_LVL_ADDR, 16'h0053);
    @(posedge clk);
    portBoard <= 8'hA5;
    rd("port level", PORT_LVL_ADDR, 16'h00A3);
    chk("serial mode", 16'h0000, {15'h0000, sharedSerialMode});
    $display("test port done");
  endtask : testPort
  task automatic testExt();
    wr(EXT_BASE_ADDR, 16'hFFFF);
    wr(16'h4401, 16'h00FF);
    wr(16'h4402, 16'h1234);
    chk("ext oe", 16'hFF00, extPinOeN[15:0]);
    chk("ext off", 16'hFFFF, extPinOeN[31:16]);
    chk("ext out", 16'h0034, {8'h00, extPinOut[7:0]});
    rd("ext level", 16'h4402, {extBoard[15:8], 8'h34});
    wr(16'h4406, 16'hFFFF);
    rd("ext set2", 16'h4406, 16'h3FFF);
    rd("unmapped", 16'h4409, 16'h0000);
    @(posedge clk);
    busMuxMode <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("ext released", 16'hFFFF, extPinOeN[15:0]);
    chk("ext active", 16'h0000, {15'h0000, extIoActive});
    $display("test ext done");
  endtask : testExt
  // Second reset with the strap pin high, then the strap dropped.
  task automatic testStrap();
    @(posedge clk);
    portBoard <= 8'h80;
    arst_n <= 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("serial mode", 16'h0001, {15'h0000, sharedSerialMode});
    chk("shared oe", 16'h0000, {14'h0000, portPinOeN[5], portPinOeN[3]});
    chk("shared out", 16'h0001, {14'h0000, portPinOut[5], portPinOut[3]});
    @(posedge clk);
    portBoard <= 8'h00;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("serial mode", 16'h0001, {15'h0000, sharedSerialMode});
    $display("test strap done");
  endtask : testStrap
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Main sequence; inputs get values at time zero, reset held 20 cycles.
  initial begin
    {arst_n, regSel, regWrite, busMuxMode, s2Clk, s2ClkOeN, s2Fs, s2FsOeN} = 8'h08;
    {regAddr, regWdata} = 32'h0000_0000;
    portBoard = 8'h5A;
    extBoard = 46'h2AAA_5A5A_C3C3;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    testReset();
    testPort();
    testExt();
    testStrap();
    testDone();
  end
endmodule : tb_top
`default_nettype wire
